/* pkg/ibs_pkg.sv */
/*
 * Shared constants and types for the I2C master byte sequencer.
 * Assumes a 25 MHz APB clock that also paces the baud counter.
 */
package ibs_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned PCLK_NS        = 40;
	localparam int unsigned INSTR_CYCLE_NS = 80;
	localparam int unsigned WRITE_COLLISION_FLAG_WIN_NS    = 2 * INSTR_CYCLE_NS;
	localparam logic [7:0]  WRITE_COLLISION_FLAG_WIN_CYC   = 8'(WRITE_COLLISION_FLAG_WIN_NS / PCLK_NS);
	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFS_XFER_BUFFER = 12'h000;
	localparam logic [11:0] OFS_CONTROL_TWO = 12'h004;
	localparam logic [11:0] OFS_PORT_STATUS = 12'h008;
	localparam logic [11:0] OFS_BAUD_RELOAD = 12'h00c;
	// ==========================================================
	// Field positions
	localparam int unsigned C2_ACK_STATUS = 6;
	localparam int unsigned C2_ACK_DATA   = 5;
	localparam int unsigned C2_ACK_EN     = 4;
	localparam int unsigned C2_RCV_EN     = 3;
	localparam int unsigned C2_STOP_EN    = 2;
	localparam int unsigned ST_BF         = 0;
	localparam int unsigned ST_STOP       = 4;
	localparam int unsigned ST_IF         = 5;
	localparam int unsigned ST_OVF        = 6;
	localparam int unsigned ST_WRITE_COLLISION_FLAG       = 7;
	// ==========================================================
	// Reset values
	localparam logic [6:0]  BAUD_RST = 7'h09;
	localparam logic [7:0]  BUF_RST  = 8'h00;
	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		IBS_IDLE     = 4'h0,
		IBS_LOW      = 4'h1,
		IBS_REL      = 4'h3,
		IBS_HIGH     = 4'h2,
		IBS_STP_SDA  = 4'h6,
		IBS_STP_LOW  = 4'h7,
		IBS_STP_REL  = 4'h5,
		IBS_STP_HIGH = 4'h4,
		IBS_STP_CHK  = 4'hc,
		IBS_STP_END  = 4'hd
	} ibs_state_t;
	typedef enum logic [1:0] {
		IBS_OP_TX   = 2'h0,
		IBS_OP_RX   = 2'h1,
		IBS_OP_ACK  = 2'h2,
		IBS_OP_STOP = 2'h3
	} ibs_op_t;
	typedef struct packed {
		logic ack_status;
		logic ack_data;
		logic ack_en;
		logic rcv_en;
		logic stop_en;
	} ibs_con2_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} ibs_line_t;
endpackage : ibs_pkg

/* hdl/ibs_sequencer.sv */
/*
 * I2C master byte sequencer: transmit, receive, acknowledge and Stop,
 * with an APB register slave. Assumes open-drain pads outside and an
 * external Repeated Start engine that reports when it is busy.
 */
`timescale 1ns/1ps
// Summary of operation
// - Idle buffer write sets full flag, starts baud counter, shifts byte out.
// - Data changes only with clock low, Stop excepted; low one period, high one period.
// - Address byte: seven address bits then direction bit, one per clock.
// - After eighth falling edge clear full flag and release data.
// - Ninth falling edge samples data into ack status, bit 6.
// - After ninth clock set interrupt flag, hold clock low, data floating.
// - Transmit full flag set by buffer write, cleared after eight bits.
// - Write during shifting sets collision; early writes still update buffer.
// - Collision flag is cleared only by software.
// - Write during receive, acknowledge, Stop or Repeated Start: collision, no change.
// - Whole control register, ack data included, locked while Repeated Start runs.
// - Receive enable starts reception only when idle.
// - Reception toggles clock each period; data shifted in on rising edges.
// - After eighth falling edge store byte, flag full and interrupt, idle.
// - Buffer read in receive operation clears full flag.
// - Byte completing while full flag set raises overflow.
// - Acknowledge: clock low, drive ack data, one period, release clock.
// - Clock seen high: one more period, clock low, clear enable, idle.
// - Stop: data low; seen low, count, release clock, then data.
// - Data high with clock high sets stop bit; later interrupt, enable cleared.
// - Baud counter reloads from seven bits, counts to zero, stops.
// - Released clock suspends counter until the line reads high.
module ibs_sequencer #(
	parameter int unsigned BAUD_W = 7
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Repeated Start engine status, same clock
	input  wire logic        rep_start_busy,
	// Serial clock line
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	// Serial data line
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);
	import ibs_pkg::*;

	// Reload register is seven bits wide, so the counter cannot be wider
	if (BAUD_W < 1 || BAUD_W > 7) begin : g_baud_w_check
		$error("BAUD_W must lie in 1..7");
	end

	// ==========================================================
	// Pin synchronisers
	ibs_line_t s1_r, ln_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '1;
			ln_r <= '1;
		end else begin
			s1_r <= '{scl: scl_i, sda: sda_i};
			ln_r <= s1_r;
		end
	end

	// ==========================================================
	// State
	ibs_state_t        st_r, st_nxt;
	ibs_op_t           op_r;
	ibs_con2_t         con2_r;
	logic [3:0]        bit_r;
	logic [BAUD_W-1:0] cnt_r;
	logic [6:0]        baud_r;
	logic [7:0]        buf_r, tx_sh_r, rx_sh_r, age_r;
	logic              bf_r, write_collision_flag_r, ovf_r, if_r, stop_r, hold_r, rxm_r;
	logic              scl_oe_r, sda_oe_r;
	logic [31:0]       prdata_r;

	// ==========================================================
	// APB decode
	wire acc      = psel && penable;
	wire sel_buf  = paddr == OFS_XFER_BUFFER;
	wire sel_con2 = paddr == OFS_CONTROL_TWO;
	wire sel_stat = paddr == OFS_PORT_STATUS;
	wire sel_baud = paddr == OFS_BAUD_RELOAD;
	wire hit      = sel_buf || sel_con2 || sel_stat || sel_baud;
	wire wr       = acc && pwrite && hit;
	wire wr_buf   = wr && sel_buf;
	wire wr_c2raw = wr && sel_con2;
	wire wr_con2  = wr_c2raw && !rep_start_busy;
	wire wr_stat  = wr && sel_stat;
	wire rd_buf   = acc && !pwrite && sel_buf;
	wire [31:0] con2_rd = {25'h0, con2_r.ack_status, con2_r.ack_data,
		con2_r.ack_en, con2_r.rcv_en, con2_r.stop_en, 2'h0};
	wire [31:0] stat_rd = {24'h0, write_collision_flag_r, ovf_r, if_r, stop_r, 3'h0, bf_r};
	wire [31:0] rdata = sel_buf ? {24'h0, buf_r} :
		sel_con2 ? con2_rd : sel_stat ? stat_rd :
		sel_baud ? {25'h0, baud_r} : 32'h0;
	assign pready  = acc;
	assign pslverr = acc && !hit;
	assign prdata  = prdata_r;

	// ==========================================================
	// Command acceptance
	wire idle    = st_r == IBS_IDLE;
	wire go_tx   = wr_buf && idle && !rep_start_busy;
	wire tx_busy = !idle && op_r == IBS_OP_TX;
	wire wr_upd  = wr_buf && tx_busy && age_r < WRITE_COLLISION_FLAG_WIN_CYC;
	wire write_collision_flag_ev = wr_buf && !go_tx;
	// One command per write, and only from idle
	wire go_stop = wr_con2 && idle && pwdata[C2_STOP_EN];
	wire go_ack  = wr_con2 && idle && !go_stop && pwdata[C2_ACK_EN];
	wire go_rx   = wr_con2 && idle && !go_stop && !go_ack && pwdata[C2_RCV_EN];

	// ==========================================================
	// Baud counter
	logic ld, fall;
	wire counting = st_r inside {IBS_LOW, IBS_HIGH, IBS_STP_LOW, IBS_STP_HIGH, IBS_STP_END};
	wire tmo      = counting && cnt_r == '0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= '0;
		else if (ld)
			cnt_r <= baud_r[BAUD_W-1:0];
		else if (counting && cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	// ==========================================================
	// Sequencer
	wire last_bit = (op_r == IBS_OP_TX && bit_r == 4'h8) ||
		(op_r == IBS_OP_RX && bit_r == 4'h7) || op_r == IBS_OP_ACK;
	always_comb begin
		st_nxt = st_r;
		ld     = 1'b0;
		fall   = 1'b0;
		unique case (st_r)
			IBS_IDLE: begin
				if (go_tx || go_rx || go_ack) begin
					st_nxt = IBS_LOW;
					ld     = 1'b1;
				end else if (go_stop)
					st_nxt = IBS_STP_SDA;
			end
			IBS_LOW: begin
				if (tmo)
					st_nxt = IBS_REL;
			end
			IBS_REL: begin
				if (ln_r.scl) begin
					st_nxt = IBS_HIGH;
					ld     = 1'b1;
				end
			end
			IBS_HIGH: begin
				if (tmo) begin
					fall = 1'b1;
					ld   = !last_bit;
					st_nxt = last_bit ? IBS_IDLE : IBS_LOW;
				end
			end
			IBS_STP_SDA: begin
				if (!ln_r.sda) begin
					st_nxt = IBS_STP_LOW;
					ld     = 1'b1;
				end
			end
			IBS_STP_LOW: begin
				if (tmo)
					st_nxt = IBS_STP_REL;
			end
			IBS_STP_REL: begin
				if (ln_r.scl) begin
					st_nxt = IBS_STP_HIGH;
					ld     = 1'b1;
				end
			end
			IBS_STP_HIGH: begin
				if (tmo)
					st_nxt = IBS_STP_CHK;
			end
			IBS_STP_CHK: begin
				if (ln_r.sda && ln_r.scl) begin
					st_nxt = IBS_STP_END;
					ld     = 1'b1;
				end
			end
			IBS_STP_END: begin
				if (tmo)
					st_nxt = IBS_IDLE;
			end
			default: st_nxt = IBS_IDLE;
		endcase
	end

	// ==========================================================
	// Events
	wire tx_b7     = fall && op_r == IBS_OP_TX && bit_r == 4'h7;
	wire tx_done   = fall && op_r == IBS_OP_TX && bit_r == 4'h8;
	wire rx_done   = fall && op_r == IBS_OP_RX && bit_r == 4'h7;
	wire ack_done  = fall && op_r == IBS_OP_ACK;
	wire stop_seen = st_r == IBS_STP_CHK && ln_r.sda && ln_r.scl;
	wire stop_done = st_r == IBS_STP_END && tmo;
	wire rx_edge   = st_r == IBS_REL && ln_r.scl && op_r == IBS_OP_RX;
	// Clock stays low after a byte or acknowledge until a Stop takes over
	wire hold_nxt  = (hold_r || tx_done || rx_done || ack_done) &&
		!(st_r == IBS_STP_LOW && tmo);
	wire scl_nxt   = st_nxt inside {IBS_LOW, IBS_STP_SDA, IBS_STP_LOW} ||
		(st_nxt == IBS_IDLE && hold_nxt);
	// Data follows the clock by one cycle, so it never moves while high except when released for the Stop
	wire sda_lowp  = op_r == IBS_OP_TX ? (bit_r != 4'h8 && !tx_sh_r[7]) :
		op_r == IBS_OP_ACK ? !con2_r.ack_data : 1'b0;
	wire sda_nxt   = st_r == IBS_LOW ? sda_lowp :
		st_r inside {IBS_REL, IBS_HIGH} ? sda_oe_r :
		st_r inside {IBS_STP_SDA, IBS_STP_LOW, IBS_STP_REL, IBS_STP_HIGH};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r     <= IBS_IDLE;
			op_r     <= IBS_OP_TX;
			bit_r    <= 4'h0;
			hold_r   <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			hold_r   <= hold_nxt;
			scl_oe_r <= scl_nxt;
			sda_oe_r <= sda_nxt;
			if (go_tx)
				op_r <= IBS_OP_TX;
			else if (go_rx)
				op_r <= IBS_OP_RX;
			else if (go_ack)
				op_r <= IBS_OP_ACK;
			else if (go_stop)
				op_r <= IBS_OP_STOP;
			if (idle)
				bit_r <= 4'h0;
			else if (fall)
				bit_r <= bit_r + 4'h1;
		end
	end
	assign scl_o  = 1'b0;
	assign sda_o  = 1'b0;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;

	// ==========================================================
	// Data path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_r    <= BUF_RST;
			tx_sh_r  <= BUF_RST;
			rx_sh_r  <= BUF_RST;
			baud_r   <= BAUD_RST;
			age_r    <= WRITE_COLLISION_FLAG_WIN_CYC;
			prdata_r <= 32'h0;
		end else begin
			if (go_tx || wr_upd) begin
				buf_r   <= pwdata[7:0];
				tx_sh_r <= pwdata[7:0];
			end else begin
				if (rx_done)
					buf_r <= rx_sh_r;
				if (fall && op_r == IBS_OP_TX)
					tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end
			if (rx_edge)
				rx_sh_r <= {rx_sh_r[6:0], ln_r.sda};
			if (wr && sel_baud)
				baud_r <= pwdata[6:0];
			if (go_tx)
				age_r <= 8'h0;
			else if (age_r < WRITE_COLLISION_FLAG_WIN_CYC)
				age_r <= age_r + 8'h1;
			if (psel && !penable)
				prdata_r <= rdata;
		end
	end

	// ==========================================================
	// Control and status flags; a hardware set wins over a clear
	wire clr_if   = wr_stat && pwdata[ST_IF];
	wire clr_ovf  = wr_stat && pwdata[ST_OVF];
	wire clr_write_collision_flag = wr_stat && pwdata[ST_WRITE_COLLISION_FLAG];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con2_r <= '0;
			bf_r   <= 1'b0;
			write_collision_flag_r <= 1'b0;
			ovf_r  <= 1'b0;
			if_r   <= 1'b0;
			stop_r <= 1'b0;
			rxm_r  <= 1'b0;
		end else begin
			if (wr_con2)
				con2_r.ack_data <= pwdata[C2_ACK_DATA];
			if (tx_done)
				con2_r.ack_status <= ln_r.sda;
			con2_r.stop_en <= go_stop || (con2_r.stop_en && !stop_done);
			con2_r.ack_en  <= go_ack || (con2_r.ack_en && !ack_done);
			con2_r.rcv_en  <= go_rx || (con2_r.rcv_en && !rx_done);
			bf_r   <= go_tx || rx_done ||
				(bf_r && !tx_b7 && !(rd_buf && rxm_r));
			write_collision_flag_r <= write_collision_flag_ev || (write_collision_flag_r && !clr_write_collision_flag);
			ovf_r  <= (rx_done && bf_r) || (ovf_r && !clr_ovf);
			if_r   <= tx_done || rx_done || stop_done || (if_r && !clr_if);
			stop_r <= stop_seen || (stop_r && !go_tx);
			if (go_tx)
				rxm_r <= 1'b0;
			else if (rx_done)
				rxm_r <= 1'b1;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_tx_start_full: assert property (go_tx |=> bf_r && st_r == IBS_LOW)
		else $error("buffer write did not start transmission");
	a_sda_clock_low: assert property (op_r == IBS_OP_TX && $changed(sda_oe_r) |-> scl_oe_r)
		else $error("data moved while clock released");
	a_bit_order: assert property (st_r == IBS_HIGH && op_r == IBS_OP_TX && bit_r < 4'h8
		|-> sda_oe_r == !tx_sh_r[7])
		else $error("wrong bit on data line");
	a_ack_release: assert property (tx_b7 |=> !bf_r ##1 !sda_oe_r)
		else $error("data not released for acknowledge");
	a_ack_sample: assert property (tx_done |=> con2_r.ack_status == $past(ln_r.sda))
		else $error("acknowledge status not sampled");
	a_tx_suspend: assert property (tx_done |=> if_r && idle && scl_oe_r && !sda_oe_r)
		else $error("no suspend after ninth clock");
	a_write_collision_flag_late: assert property (wr_buf && tx_busy && age_r >= WRITE_COLLISION_FLAG_WIN_CYC
		|=> write_collision_flag_r && $stable(buf_r))
		else $error("late write altered buffer");
	a_write_collision_flag_sticky: assert property (write_collision_flag_r && !clr_write_collision_flag |=> write_collision_flag_r)
		else $error("collision flag dropped by itself");
	a_write_collision_flag_other: assert property (wr_buf && !idle && op_r != IBS_OP_TX
		|=> write_collision_flag_r && $stable(buf_r))
		else $error("write accepted during other operation");
	a_rs_lock: assert property (wr_c2raw && rep_start_busy && idle |=> $stable(con2_r))
		else $error("control written during Repeated Start");
	a_rx_finish: assert property (rx_done |=> !con2_r.rcv_en && bf_r && if_r && idle
		&& buf_r == $past(rx_sh_r))
		else $error("reception did not complete");
	a_rx_ovf: assert property (rx_done && bf_r |=> ovf_r)
		else $error("overflow missed");
	a_stretch: assert property (st_r inside {IBS_REL, IBS_STP_REL} && !ln_r.scl
		|=> $stable(st_r) && $stable(cnt_r))
		else $error("counter ran while clock held low");
	a_stop_end: assert property (stop_seen |=> stop_r ##[1:129] (!con2_r.stop_en && if_r))
		else $error("Stop did not finish");

	c_tx_byte: cover property (tx_done);
	c_rx_byte: cover property (rx_done ##[1:50] rd_buf);
	c_stop: cover property (stop_done);
	c_write_collision_flag_early: cover property (wr_upd);
endmodule : ibs_sequencer

/* dv/ibs_slave_model.sv */
/*
 * Behavioural two-wire slave for the sequencer bench: listens and
 * acknowledges, or sends a byte, and can stretch the clock.
 * Assumes pulled-up wire levels and a bench that arms it per byte.
 */
`timescale 1ns/1ps
module ibs_slave_model (
	// Clock and control
	input  wire logic       pclk,
	input  wire logic       arm,
	input  wire logic       send,
	input  wire logic       ack_on,
	input  wire logic [7:0] byte_in,
	input  wire logic [3:0] stretch,
	// Wire levels
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            scl_low,
	output logic            sda_low,
	// Observations
	output logic [7:0]      rx_byte,
	output logic            rise_bit,
	output int              stops
);
	// ==========================================================
	// Bit tracking
	logic scl_q;
	logic sda_q;
	int   bits;
	int   hold;
	initial begin
		sda_low = 1'b0;
		hold = 0;
		bits = 0;
		stops = 0;
	end
	// Holds the clock low after each fall so the master must wait
	assign scl_low = hold != 0;
	always @(posedge pclk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (hold != 0)
			hold <= hold - 1;
		if (sda && !sda_q && scl)
			stops <= stops + 1;
		if (scl && !scl_q) begin
			rise_bit <= sda;
			if (!send && bits < 8)
				rx_byte <= {rx_byte[6:0], sda};
		end
		if (!scl && scl_q) begin
			bits <= bits + 1;
			hold <= int'(stretch);
			// Released line goes high through the pull-up
			if (send)
				sda_low <= bits < 7 && !byte_in[6-bits];
			else
				sda_low <= bits == 7 && ack_on;
		end
		if (arm) begin
			// An idle high clock will fall once before the first bit
			bits <= scl ? -1 : 0;
			stops <= 0;
			sda_low <= send && !byte_in[7];
		end
	end
endmodule : ibs_slave_model

/* dv/ibs_sequencer_bench.sv */
/*
 * Self-checking bench for the sequencer: APB tasks, a slave model.
 * Assumes zero-wait APB slave and the register map of the package.
 */
`timescale 1ns/1ps
module ibs_sequencer_bench;
	import ibs_pkg::*;
	localparam logic [11:0] AB = OFS_XFER_BUFFER;
	localparam logic [11:0] AC = OFS_CONTROL_TWO;
	localparam logic [11:0] AS = OFS_PORT_STATUS;
	logic        pclk, presetn, psel, penable, pwrite, rep_start_busy, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, scl, sda;
	logic        arm, send, ack_on, s_scl_low, s_sda_low, rise_bit, sda_oe_q, wire_on;
	logic [7:0]  byte_in, rx_byte;
	logic [3:0]  stretch;
	int          stops, mismatches, check_count, i;
	// ==========================================================
	// Open-drain wires with pull-ups
	assign scl = !((scl_oe && !scl_o) || s_scl_low);
	assign sda = !((sda_oe && !sda_o) || s_sda_low);
	ibs_sequencer ibs_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rep_start_busy(rep_start_busy), .scl_i(scl), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	ibs_slave_model ibs_slave_model_i (.pclk(pclk), .arm(arm), .send(send), .ack_on(ack_on),
		.byte_in(byte_in), .stretch(stretch), .scl(scl), .sda(sda), .scl_low(s_scl_low),
		.sda_low(s_sda_low), .rx_byte(rx_byte), .rise_bit(rise_bit), .stops(stops));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// ==========================================================
	// Tasks
	task stop_test;
		if (mismatches == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		q = prdata;
		perr = pslverr;
		if (n >= 40) begin
			mismatches++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd
	task poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] w);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((q & m) !== w && n < 400);
		if (n >= 400) begin
			mismatches++;
			stop_test();
		end
	endtask : poll
	task slave(input logic s, input logic a, input logic [7:0] b, input logic [3:0] st);
		send <= s;
		ack_on <= a;
		byte_in <= b;
		stretch <= st;
		arm <= 1'b1;
		@(posedge pclk);
		arm <= 1'b0;
	endtask : slave
	// Data line may only move while the clock is low, Stop excepted
	always @(posedge pclk) begin
		sda_oe_q <= sda_oe;
		if (wire_on && sda_oe !== sda_oe_q)
			chk({31'h0, scl}, 32'h0);
	end
	// ==========================================================
	// Sequence
	initial begin
		{presetn, psel, penable, pwrite, rep_start_busy, arm, send, ack_on, wire_on} = 9'h0;
		{paddr, pwdata, byte_in, stretch} = 56'h0;
		mismatches = 0;
		check_count = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wire_on <= 1'b1;
		@(posedge pclk);
		rd(OFS_BAUD_RELOAD, 32'h09);
		rd(AC, 32'h0);
		rd(AS, 32'h0);
		chk({30'h0, scl_oe, sda_oe}, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, perr}, 32'h1);
		// Long enough that an early rewrite lands while the clock is low
		apb(1'b1, OFS_BAUD_RELOAD, 32'h05);
		// Address byte acknowledged; a late rewrite is discarded
		slave(1'b0, 1'b1, 8'h00, 4'h0);
		apb(1'b1, AB, 32'ha4);
		rd(AS, 32'h01);
		apb(1'b1, AB, 32'h55);
		poll(AS, 32'h20, 32'h20);
		chk({24'h0, rx_byte}, 32'ha4);
		rd(AC, 32'h0);
		rd(AS, 32'ha0);
		rd(AB, 32'ha4);
		chk({31'h0, scl_oe}, 32'h1);
		apb(1'b1, AS, 32'ha0);
		// Rewrite within the window replaces the byte; slave stretches and refuses
		slave(1'b0, 1'b0, 8'h00, 4'hc);
		apb(1'b1, AB, 32'h0f);
		apb(1'b1, AB, 32'hf0);
		poll(AS, 32'h20, 32'h20);
		chk({24'h0, rx_byte}, 32'hf0);
		rd(AC, 32'h40);
		rd(AS, 32'ha0);
		apb(1'b1, AS, 32'ha0);
		// Repeated Start busy locks buffer and control writes
		rep_start_busy <= 1'b1;
		apb(1'b1, AB, 32'h33);
		apb(1'b1, AC, 32'h08);
		rd(AC, 32'h40);
		rd(AS, 32'h80);
		rep_start_busy <= 1'b0;
		apb(1'b1, AS, 32'h80);
		// Reception; buffer write and Stop request meanwhile are refused
		slave(1'b1, 1'b0, 8'h96, 4'h0);
		apb(1'b1, AC, 32'h08);
		apb(1'b1, AB, 32'h77);
		apb(1'b1, AC, 32'h04);
		poll(AS, 32'h20, 32'h20);
		rd(AS, 32'ha1);
		rd(AC, 32'h40);
		rd(AB, 32'h96);
		rd(AS, 32'ha0);
		apb(1'b1, AS, 32'ha0);
		for (i = 0; i < 2; i++) begin
			slave(1'b1, 1'b0, i ? 8'hc3 : 8'h3c, 4'h0);
			apb(1'b1, AC, 32'h08);
			// Interrupt flag stays set from the first byte; wait on the enable
			poll(AC, 32'h08, 32'h0);
		end
		rd(AS, 32'h61);
		rd(AB, 32'hc3);
		apb(1'b1, AS, 32'h60);
		// Acknowledge sequence with both data values
		for (i = 0; i < 2; i++) begin
			slave(1'b0, 1'b0, 8'h00, 4'h0);
			apb(1'b1, AC, i ? 32'h10 : 32'h20);
			apb(1'b1, AC, i ? 32'h10 : 32'h30);
			poll(AC, 32'h10, 32'h0);
			chk({31'h0, rise_bit}, i ? 32'h0 : 32'h1);
			chk({31'h0, scl_oe}, 32'h1);
		end
		// Stop condition
		slave(1'b0, 1'b0, 8'h00, 4'h0);
		wire_on <= 1'b0;
		apb(1'b1, AC, 32'h04);
		poll(AS, 32'h20, 32'h20);
		rd(AS, 32'h30);
		rd(AC, 32'h40);
		chk({30'h0, scl_oe, sda_oe}, 32'h0);
		chk(32'(stops), 32'h1);
		stop_test();
	end
endmodule : ibs_sequencer_bench
